// ===== include/qamc_pkg.sv
// Constants and types shared by the mode control register block.
package qamc_pkg;
    // ****************************************************
    // Register map and frame layout
    // ****************************************************
    localparam int REG_W = 16;
    localparam int ADDR_W = 7;
    localparam int FRAME_BITS = 24;
    localparam logic [ADDR_W-1:0] ADDR_CHIP_ID = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_MODE_CTRL = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET = 7'h04;
    localparam logic [REG_W-1:0] MODE_CTRL_RESET = 16'h0000;
    localparam logic [4:0] CNT_ADDR_DONE = 5'h08;
    localparam logic [4:0] CNT_FRAME_DONE = 5'h18;
    // ****************************************************
    // Field positions of converter_mode_control and soft reset, sample width
    // ****************************************************
    localparam int POS_CODE_LSB = 0;
    localparam int POS_STBY_LSB = 4;
    localparam int POS_CODE_STYLE = 7;
    localparam int POS_BAND = 8;
    localparam int POS_SYNC_BEHAV = 10;
    localparam int POS_PATTERN = 12;
    localparam int POS_SOFT_RESET = 0;
    localparam int SAMPLE_W = 10;
    // ****************************************************
    // Power-down select codes
    // ****************************************************
    localparam logic [1:0] STBY_NONE = 2'h0;
    localparam logic [1:0] STBY_AB = 2'h1;
    localparam logic [1:0] STBY_CD = 2'h2;
    localparam logic [1:0] STBY_ALL = 2'h3;
    typedef enum logic [1:0] {
        KIND_FOUR = 2'b00,
        KIND_TWO = 2'b01,
        KIND_ONE = 2'b10,
        KIND_COMMON = 2'b11
    } qamc_kind_e;
    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_ADDR = 2'b01,
        SPI_DATA = 2'b10,
        SPI_WAIT = 2'b11
    } qamc_spi_e;
endpackage : qamc_pkg

// ===== hw/qamc_decode.sv
// Channel-mode and standby decoder for the mode control register.
`timescale 1ns/1ps
module qamc_decode (
    input wire logic [3:0] channel_config_code, // Channel configuration code.
    input wire logic [1:0] power_down_select, // Standby selection.
    output qamc_pkg::qamc_kind_e kind, // Operating mode kind.
    output logic [1:0] input_sel, // Pairing or source channel index.
    output logic [3:0] chan_standby // Standby per channel, bit 0 is A.
);
    always_comb begin
        kind = qamc_pkg::qamc_kind_e'(channel_config_code[3:2]);
        input_sel = (kind == qamc_pkg::KIND_FOUR) ? 2'h0 : channel_config_code[1:0];
        chan_standby = 4'h0;
        unique case (power_down_select)
            qamc_pkg::STBY_NONE: begin
                chan_standby = 4'h0;
            end
            qamc_pkg::STBY_ALL: begin
                chan_standby = 4'hF;
            end
            qamc_pkg::STBY_AB: begin
                if (kind == qamc_pkg::KIND_FOUR) begin
                    chan_standby = 4'h3;
                end else if (kind == qamc_pkg::KIND_TWO) begin
                    chan_standby = channel_config_code[0] ? 4'h2 : 4'h1;
                end else begin
                    chan_standby = 4'hF;
                end
            end
            qamc_pkg::STBY_CD: begin
                if (kind == qamc_pkg::KIND_FOUR) begin
                    chan_standby = 4'hC;
                end else if (kind == qamc_pkg::KIND_TWO) begin
                    chan_standby = channel_config_code[1] ? 4'h8 : 4'h4;
                end else begin
                    chan_standby = 4'hF;
                end
            end
        endcase
    end
endmodule : qamc_decode

// ===== hw/qamc_top.sv
// Mode control register with serial port access and decoded control outputs.
// Overview of operation
// - Mode control register at 0x01 holds code, standby, style, band, sync and pattern fields.
// - Upper code bits zero select four independent cores.
// - Codes 0100 and 0101 pair A with C and B with C.
// - Codes 0110 and 0111 pair A with D and B with D.
// - Codes 1000 to 1011 interleave all cores from source A to D.
// - Codes 1100 to 1111 give a common input from source A to D.
// - Standby select 01 in four-channel mode idles channels A and B.
// - Standby select 01 in two-channel mode idles the paired A or B.
// - Standby select 10 idles C and D, or the paired C or D.
// - Select 01 or 10 in one-channel or common mode gives full standby.
// - Band select 0 gives nominal bandwidth, 1 gives full bandwidth.
// - Pattern enable replaces converted samples with the test pattern.
// - Sync behaviour 0 holds internal clocks while sync is asserted.
// - Sync behaviour 1 keeps clocks and valid strobe running during sync.
// - Earlier revision always behaves as if sync behaviour were 0.
// - Every register is sixteen bits wide.
// - Hardware reset or soft reset write restores the register default.
`timescale 1ns/1ps
module qamc_top #(
    parameter bit EARLY_REVISION = 1'b0, // Revision without the sync behaviour option.
    parameter logic [15:0] CHIP_ID_VALUE = 16'h0A5A // Arbitrary identification value.
) (
    input wire logic clk, // System clock, 250 MHz.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic spi_sclk, // Serial clock pin.
    input wire logic spi_csn, // Serial chip select pin, active low.
    input wire logic spi_mosi, // Serial data in pin.
    output logic spi_miso, // Serial data out pin.
    input wire logic alignment_pulse, // Received sync level from the pin pair.
    input wire logic [9:0] sample_in, // Converted sample, straight binary.
    input wire logic [9:0] test_pattern, // Pattern chosen by the test register.
    output logic [9:0] sample_out, // Output sample.
    output qamc_pkg::qamc_kind_e mode_kind, // Operating mode kind.
    output logic [1:0] input_sel, // Pairing or source channel index.
    output logic [3:0] chan_standby, // Standby per channel, bit 0 is A.
    output logic full_bandwidth, // Full input bandwidth selected.
    output logic clocks_hold, // Internal clocks held static.
    output logic strobe_hold // Output valid strobe held static.
);
    // ****************************************************
    // State
    // ****************************************************
    typedef struct packed {
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic sclk_prev;
        logic sync_s1;
        logic sync_s2;
        qamc_pkg::qamc_spi_e spi_st;
        logic [4:0] cnt;
        logic is_write;
        logic [15:0] shift_in;
        logic [15:0] shift_out;
        logic [6:0] addr;
        logic miso;
        logic [15:0] ctrl;
        logic [9:0] sample;
        qamc_pkg::qamc_kind_e kind;
        logic [1:0] sel;
        logic [3:0] stby;
        logic full_bw;
        logic clk_hold;
        logic stb_hold;
    } qamc_state_s;

    qamc_state_s r;
    qamc_state_s next_r;
    qamc_pkg::qamc_kind_e dec_kind;
    logic [1:0] dec_sel;
    logic [3:0] dec_stby;
    logic sclk_rise;
    logic sclk_fall;
    logic wr_ctrl;
    logic wr_soft;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic sync_behav;

    qamc_decode u_decode (
        .channel_config_code(r.ctrl[qamc_pkg::POS_CODE_LSB +: 4]),
        .power_down_select(r.ctrl[qamc_pkg::POS_STBY_LSB +: 2]),
        .kind(dec_kind),
        .input_sel(dec_sel),
        .chan_standby(dec_stby)
    );

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb begin
        next_r = r;
        next_r.pin_s1 = {spi_sclk, spi_csn, spi_mosi};
        next_r.pin_s2 = r.pin_s1;
        next_r.sclk_prev = r.pin_s2[2];
        next_r.sync_s1 = alignment_pulse;
        next_r.sync_s2 = r.sync_s1;
        sclk_rise = r.pin_s2[2] & ~r.sclk_prev & ~r.pin_s2[1];
        sclk_fall = ~r.pin_s2[2] & r.sclk_prev & ~r.pin_s2[1];
        wr_data = {r.shift_in[14:0], r.pin_s2[0]};
        unique case (r.addr)
            qamc_pkg::ADDR_CHIP_ID: rd_data = CHIP_ID_VALUE;
            qamc_pkg::ADDR_MODE_CTRL: rd_data = r.ctrl;
            default: rd_data = 16'h0000;
        endcase
        wr_ctrl = 1'b0;
        wr_soft = 1'b0;
        if (r.pin_s2[1]) begin
            next_r.spi_st = qamc_pkg::SPI_IDLE;
            next_r.cnt = 5'h00;
        end else if (sclk_rise) begin
            next_r.cnt = r.cnt + 5'h01;
            next_r.shift_in = wr_data;
            unique case (r.spi_st)
                qamc_pkg::SPI_IDLE: begin
                    next_r.is_write = r.pin_s2[0];
                    next_r.spi_st = qamc_pkg::SPI_ADDR;
                end
                qamc_pkg::SPI_ADDR: begin
                    if (r.cnt == qamc_pkg::CNT_ADDR_DONE - 5'h01) begin
                        next_r.addr = wr_data[6:0];
                        next_r.spi_st = qamc_pkg::SPI_DATA;
                    end
                end
                qamc_pkg::SPI_DATA: begin
                    if (r.cnt == qamc_pkg::CNT_FRAME_DONE - 5'h01) begin
                        next_r.spi_st = qamc_pkg::SPI_WAIT;
                        wr_ctrl = r.is_write & (r.addr == qamc_pkg::ADDR_MODE_CTRL);
                        wr_soft = r.is_write & (r.addr == qamc_pkg::ADDR_SOFT_RESET)
                            & wr_data[qamc_pkg::POS_SOFT_RESET];
                    end
                end
                qamc_pkg::SPI_WAIT: begin
                    next_r.spi_st = qamc_pkg::SPI_WAIT;
                end
            endcase
        end else if (sclk_fall) begin
            if (r.spi_st == qamc_pkg::SPI_DATA && r.cnt == qamc_pkg::CNT_ADDR_DONE) begin
                next_r.miso = rd_data[15];
                next_r.shift_out = {rd_data[14:0], 1'b0};
            end else begin
                next_r.miso = r.shift_out[15];
                next_r.shift_out = {r.shift_out[14:0], 1'b0};
            end
        end
        if (wr_ctrl) begin
            next_r.ctrl = wr_data;
        end
        if (wr_soft) begin
            next_r.ctrl = qamc_pkg::MODE_CTRL_RESET;
        end
        // Mode and pairing from the decoder.
        next_r.kind = dec_kind;
        next_r.sel = dec_sel;
        next_r.stby = dec_stby;
        next_r.full_bw = r.ctrl[qamc_pkg::POS_BAND];
        // Earlier revision ignores the sync behaviour bit.
        sync_behav = r.ctrl[qamc_pkg::POS_SYNC_BEHAV] & ~EARLY_REVISION;
        // Clock and strobe hold during sync.
        next_r.clk_hold = r.sync_s2 & ~sync_behav;
        next_r.stb_hold = r.sync_s2 & ~sync_behav;
        if (r.ctrl[qamc_pkg::POS_PATTERN]) begin
            next_r.sample = test_pattern;
        end else if (r.ctrl[qamc_pkg::POS_CODE_STYLE]) begin
            next_r.sample = sample_in ^ {1'b0, sample_in[9:1]};
        end else begin
            next_r.sample = sample_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
            r.ctrl <= qamc_pkg::MODE_CTRL_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign spi_miso = r.miso;
    assign sample_out = r.sample;
    assign mode_kind = r.kind;
    assign input_sel = r.sel;
    assign chan_standby = r.stby;
    assign full_bandwidth = r.full_bw;
    assign clocks_hold = r.clk_hold;
    assign strobe_hold = r.stb_hold;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_ctrl_write: assert property (wr_ctrl & ~wr_soft |=> r.ctrl == $past(wr_data))
        else $error("Mode control write not stored.");
    a_soft_reset: assert property (wr_soft |=> r.ctrl == qamc_pkg::MODE_CTRL_RESET)
        else $error("Soft reset did not clear the register.");
    a_four_mode: assert property (r.ctrl[3:2] == 2'b00 |=>
        mode_kind == qamc_pkg::KIND_FOUR && input_sel == 2'h0)
        else $error("Four-channel decode wrong.");
    a_pair_select: assert property (r.ctrl[3:2] == 2'b01 |=> input_sel == $past(r.ctrl[1:0]))
        else $error("Two-channel pairing wrong.");
    a_one_source: assert property (r.ctrl[3:2] == 2'b10 |=> mode_kind == qamc_pkg::KIND_ONE)
        else $error("One-channel decode wrong.");
    a_common_source: assert property (r.ctrl[3:2] == 2'b11 |=> mode_kind == qamc_pkg::KIND_COMMON)
        else $error("Common input decode wrong.");
    a_stby_four_ab: assert property (r.ctrl[5:0] ==? 6'b010000 |=> chan_standby == 4'h3)
        else $error("Four-channel standby of A and B wrong.");
    a_stby_two_ab: assert property (r.ctrl[5:2] == 4'b0101 |=>
        chan_standby == ($past(r.ctrl[0]) ? 4'h2 : 4'h1))
        else $error("Two-channel standby of A or B wrong.");
    a_stby_two_cd: assert property (r.ctrl[5:2] == 4'b1001 |=>
        chan_standby == ($past(r.ctrl[1]) ? 4'h8 : 4'h4))
        else $error("Two-channel standby of C or D wrong.");
    a_stby_full: assert property (r.ctrl[3] && r.ctrl[5] != r.ctrl[4] |=> chan_standby == 4'hF)
        else $error("Full standby missing in one-channel or common mode.");
    a_stby_ends: assert property (r.ctrl[5:4] == 2'b00 |=> chan_standby == 4'h0)
        else $error("Channels not active with no standby.");
    a_band_follow: assert property ($changed(r.ctrl[8]) |=> full_bandwidth == $past(r.ctrl[8]))
        else $error("Bandwidth select not followed.");
    a_pattern_out: assert property (r.ctrl[12] |=> sample_out == $past(test_pattern))
        else $error("Test pattern not output.");
    a_clock_hold: assert property (r.sync_s2 && !r.ctrl[10] |=> clocks_hold && strobe_hold)
        else $error("Clocks not held during sync.");
    a_clock_run: assert property (!EARLY_REVISION && r.ctrl[10] |=> !clocks_hold && !strobe_hold)
        else $error("Clocks held despite sync behaviour set.");
    a_gray_code: assert property (r.ctrl[7] && !r.ctrl[12] |=>
        sample_out == ($past(sample_in) ^ ($past(sample_in) >> 1)))
        else $error("Gray coding wrong.");
endmodule : qamc_top

// ===== sim/qamc_spi_host.sv
// Serial host model that frames register reads and writes for the mode control block.
`timescale 1ns/1ps
module qamc_spi_host #(
    parameter int HALF = 8 // Clock cycles per serial clock half period.
) (
    input wire logic clk, // System clock.
    output logic spi_sclk, // Serial clock, low between frames.
    output logic spi_csn, // Chip select, active low.
    output logic spi_mosi, // Serial data to the device.
    input wire logic spi_miso // Serial data from the device.
);
    initial begin
        spi_sclk = 1'b0;
        spi_csn = 1'b1;
        spi_mosi = 1'b1;
    end
    // ****************************************************
    // Frame transfer
    // ****************************************************
    // One frame: write flag, address, then sixteen data bits, most significant first.
    task automatic xfer(input logic wr, input logic [6:0] addr, input logic [15:0] wdata, output logic [15:0] rdata);
        logic [23:0] frame;
        frame = {wr, addr, wdata};
        rdata = 16'h0000;
        @(posedge clk);
        spi_csn <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_mosi <= frame[i];
            repeat (HALF) @(posedge clk);
            spi_sclk <= 1'b1;
            if (i < 16) rdata[i] = spi_miso;
            repeat (HALF) @(posedge clk);
            spi_sclk <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        spi_csn <= 1'b1;
        // A released data line shows the inverse of its last bit, never a stale copy.
        spi_mosi <= ~frame[0];
        repeat (HALF) @(posedge clk);
    endtask : xfer
endmodule : qamc_spi_host

// ===== sim/qamc_top_test.sv
// Self-checking testbench for the mode control register block.
`timescale 1ns/1ps
module qamc_top_test;
    logic clk = 1'b0, nrst = 1'b0, align = 1'b0;
    logic sclk, csn, mosi, miso, hold_e, shold_e;
    logic [9:0] smp = 10'h000, pat = 10'h000, sout;
    qamc_pkg::qamc_kind_e kind;
    logic [1:0] isel;
    logic [3:0] stby;
    logic fbw, chold, shold;
    logic [15:0] v;
    int err_count = 0, n_tests = 0;
    always #2 clk = ~clk;
    qamc_spi_host host (.clk(clk), .spi_sclk(sclk), .spi_csn(csn), .spi_mosi(mosi), .spi_miso(miso));
    qamc_top #(.CHIP_ID_VALUE(16'h3C96)) dut (.clk(clk), .nrst(nrst), .spi_sclk(sclk), .spi_csn(csn),
        .spi_mosi(mosi), .spi_miso(miso), .alignment_pulse(align), .sample_in(smp), .test_pattern(pat),
        .sample_out(sout), .mode_kind(kind), .input_sel(isel), .chan_standby(stby), .full_bandwidth(fbw),
        .clocks_hold(chold), .strobe_hold(shold));
    qamc_top #(.EARLY_REVISION(1'b1)) dut_early (.clk(clk), .nrst(nrst), .spi_sclk(sclk), .spi_csn(csn),
        .spi_mosi(mosi), .spi_miso(), .alignment_pulse(align), .sample_in(smp), .test_pattern(pat),
        .sample_out(), .mode_kind(), .input_sel(), .chan_standby(), .full_bandwidth(),
        .clocks_hold(hold_e), .strobe_hold(shold_e));
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] unused;
        host.xfer(1'b1, a, d, unused);
        repeat (4) @(posedge clk);
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        host.xfer(1'b0, a, 16'h0000, d);
    endtask : rd
    function automatic logic [3:0] exp_stby(input logic [3:0] c, input logic [1:0] s);
        if (s == 2'h0) return 4'h0;
        if (s == 2'h3 || c[3]) return 4'hF;
        if (!c[2]) return (s == 2'h1) ? 4'h3 : 4'hC;
        return (s == 2'h1) ? (c[0] ? 4'h2 : 4'h1) : (c[1] ? 4'h8 : 4'h4);
    endfunction : exp_stby
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rd(qamc_pkg::ADDR_MODE_CTRL, v);
        chk("mode register", 16'h0000, v);
        chk("standby", 16'h0000, {12'h000, stby});
        rd(qamc_pkg::ADDR_CHIP_ID, v);
        chk("chip id", 16'h3C96, v);
        $display("test reset done");
        for (int c = 0; c < 16; c++) begin
            for (int s = 0; s < 4; s++) begin
                wr(qamc_pkg::ADDR_MODE_CTRL, {10'h000, s[1:0], c[3:0]});
                chk("kind", {14'h0, c[3:2]}, {14'h0, kind});
                chk("input select", c[3:2] == 2'h0 ? 16'h0 : {14'h0, c[1:0]}, {14'h0, isel});
                chk("standby", {12'h0, exp_stby(c[3:0], s[1:0])}, {12'h0, stby});
            end
        end
        $display("test modes done");
        smp <= 10'h2A5;
        pat <= 10'h155;
        wr(qamc_pkg::ADDR_MODE_CTRL, 16'h1180);
        align <= 1'b1;
        repeat (8) @(posedge clk);
        chk("clock hold", 16'h0001, {15'h0, chold});
        align <= 1'b0;
        rd(qamc_pkg::ADDR_MODE_CTRL, v);
        chk("readback", 16'h1180, v);
        chk("bandwidth", 16'h0001, {15'h0, fbw});
        chk("sample", 16'h0155, {6'h0, sout});
        wr(qamc_pkg::ADDR_MODE_CTRL, 16'h0080);
        chk("bandwidth", 16'h0000, {15'h0, fbw});
        chk("sample", 16'h03F7, {6'h0, sout});
        wr(qamc_pkg::ADDR_MODE_CTRL, 16'h0000);
        chk("sample", 16'h02A5, {6'h0, sout});
        $display("test fields done");
        align <= 1'b1;
        repeat (5) @(posedge clk);
        chk("clock hold", 16'h0001, {15'h0, chold});
        chk("strobe hold", 16'h0001, {15'h0, shold});
        wr(qamc_pkg::ADDR_MODE_CTRL, 16'h0400);
        chk("clock hold", 16'h0000, {15'h0, chold});
        chk("strobe hold", 16'h0000, {15'h0, shold});
        chk("early clock hold", 16'h0001, {15'h0, hold_e});
        chk("early strobe hold", 16'h0001, {15'h0, shold_e});
        align <= 1'b0;
        $display("test sync done");
        wr(7'h05, 16'hFFFF);
        rd(7'h05, v);
        chk("unmapped read", 16'h0000, v);
        rd(qamc_pkg::ADDR_MODE_CTRL, v);
        chk("mode register", 16'h0400, v);
        wr(qamc_pkg::ADDR_SOFT_RESET, 16'h0001);
        rd(qamc_pkg::ADDR_MODE_CTRL, v);
        chk("mode register", 16'h0000, v);
        wr(qamc_pkg::ADDR_MODE_CTRL, 16'h0126);
        chk("standby", 16'h0008, {12'h0, stby});
        chk("bandwidth", 16'h0001, {15'h0, fbw});
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk("standby", 16'h0000, {12'h0, stby});
        chk("bandwidth", 16'h0000, {15'h0, fbw});
        repeat (4) @(posedge clk);
        rd(qamc_pkg::ADDR_MODE_CTRL, v);
        chk("mode register", 16'h0000, v);
        $display("test resets done");
        test_done();
    end
endmodule : qamc_top_test
